// [logic/bdcu_params.svh]
// Constants for the background debug command unit
// Assumes inclusion by bare name from logic/ and sim/ files
`ifndef BDCU_PARAMS_SVH
`define BDCU_PARAMS_SVH

// Command opcodes on the host command port
`define BDCU_OP_RDDAT 4'h0
`define BDCU_OP_RDADR 4'h1
`define BDCU_OP_WRDAT 4'h2
`define BDCU_OP_WRADR 4'h3
`define BDCU_OP_RDSYS 4'h4
`define BDCU_OP_WRSYS 4'h5
`define BDCU_OP_READ 4'h6
`define BDCU_OP_WRITE 4'h7
`define BDCU_OP_DUMP 4'h8
`define BDCU_OP_FILL 4'h9
`define BDCU_OP_GO 4'ha
`define BDCU_OP_CALL 4'hb
`define BDCU_OP_RST 4'hc
`define BDCU_OP_NOP 4'hd

// Operand size codes
`define BDCU_SZ_BYTE 2'h0
`define BDCU_SZ_WORD 2'h1
`define BDCU_SZ_LONG 2'h2

// Peripheral reset pulse length in clock cycles
`define BDCU_RST_CYCLES 10'h200
// Stack push decrement for a long-word program counter
`define BDCU_PC_BYTES 32'h00000004
// Reset value of the peripheral reset counter
`define BDCU_CNT_RESET 10'h000

`endif

// [logic/bdcu_pkg.sv]
// Types for the background debug command unit
// Assumes bdcu_params.svh supplies the numeric constants
package bdcu_pkg;

  // Command presented by the serial front end
  typedef struct packed {
    logic [3:0] op;     // Command opcode
    logic [1:0] size;   // Memory operand size
    logic [3:0] sel;    // Register or system register select
    logic [31:0] addr;  // Byte memory address
    logic [31:0] data;  // Operand supplied by the host
  } bdcu_cmd_t;

  // Core register file access request
  typedef struct packed {
    logic rd;           // Read strobe
    logic wr;           // Write strobe
    logic sys;          // Selects system control registers
    logic [4:0] sel;    // {addr_not_data, index} or system index
    logic [31:0] data;  // Write data
  } bdcu_reg_req_t;

  // Memory access request
  typedef struct packed {
    logic rd;           // Read strobe
    logic wr;           // Write strobe
    logic [2:0] space;  // Address space function code
    logic [1:0] size;   // Operand size
    logic [31:0] addr;  // Byte address
    logic [31:0] data;  // Write data
  } bdcu_mem_req_t;

  // Controller states
  typedef enum logic [2:0] {
    BDCU_IDLE,
    BDCU_REG_WAIT,
    BDCU_MEM_WAIT,
    BDCU_CALL_SP,
    BDCU_CALL_PUSH,
    BDCU_RESP
  } bdcu_state_t;

endpackage

// [logic/bdcu_rst_pulse.sv]
// Peripheral reset pulse generator
// Assumes a single system clock and a one-cycle start strobe
`timescale 1ns/1ps
`default_nettype none
`include "bdcu_params.svh"

module bdcu_rst_pulse #(
  parameter logic [9:0] CYCLES = `BDCU_RST_CYCLES  // Pulse length in clocks
) (
  input wire logic i_sys_clk,   // System clock
  input wire logic i_rst_b,     // Synchronous active-low reset
  input wire logic i_start,     // Start strobe
  output logic o_periph_rst_b,  // Peripheral reset, active low
  output logic o_busy           // Pulse in progress
);

  // Counter and output state
  typedef struct packed {
    logic [9:0] cnt;  // Cycles remaining
    logic rst_b;      // Registered reset line
  } bdcu_pulse_t;

  bdcu_pulse_t st;       // Current state
  bdcu_pulse_t next_st;  // Next state

  // Load on start, count down to zero, line low while nonzero
  always_comb begin
    next_st = st;
    if (i_start && st.cnt == `BDCU_CNT_RESET) begin
      next_st.cnt = CYCLES;
    end else if (st.cnt != `BDCU_CNT_RESET) begin
      next_st.cnt = st.cnt - 10'h001;
    end
    next_st.rst_b = (next_st.cnt == `BDCU_CNT_RESET);
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st <= '{cnt: `BDCU_CNT_RESET, rst_b: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign o_periph_rst_b = st.rst_b;
  assign o_busy = (st.cnt != `BDCU_CNT_RESET);

  // Counter for low time of the pulse
  logic [10:0] low_cnt;
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b || st.rst_b) begin
      low_cnt <= 11'h000;
    end else begin
      low_cnt <= low_cnt + 11'h001;
    end
  end

  a_pulse_length: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    ($rose(st.rst_b)) |-> ($past(low_cnt) == 11'(CYCLES) - 11'h001))
    else $error("peripheral reset low time wrong");

  a_pulse_start: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_start && st.cnt == `BDCU_CNT_RESET) |=> !st.rst_b [*8])
    else $error("peripheral reset did not assert");

endmodule
`default_nettype wire

// [logic/bdcu_core.sv]
// Background debug command unit: executes host debug commands
// Assumes a serial front end delivering whole commands and core/memory ports
`timescale 1ns/1ps
`default_nettype none
`include "bdcu_params.svh"

// Overview of operation
// - Read data/address register, return contents
// - Write host operand into data/address register
// - Return any supervisor-readable system register
// - Write host operand into system register
// - Memory read of requested size, return data
// - Reads use source_space_select address space
// - Memory write of requested size
// - Writes use dest_space_select address space
// - Dump returns next block operand
// - Fill stores next host operand
// - Resume: flush pipeline, run from PC
// - Patch call pushes PC at stack
// - Then start executing patch code
// - Peripheral reset low for 512 clocks
// - Core itself is never reset
// - Null command changes nothing
module bdcu_core #(
  parameter logic [9:0] RST_CYCLES = `BDCU_RST_CYCLES  // Peripheral reset length
) (
  input wire logic i_sys_clk,                   // System clock, 10 MHz
  input wire logic i_rst_b,                     // Synchronous active-low reset
  input wire logic i_halted,                    // Core halted in background mode
  input wire logic i_cmd_valid,                 // Command strobe from front end
  input wire bdcu_pkg::bdcu_cmd_t i_cmd,        // Command contents
  output logic o_cmd_ready,                     // Ready for a new command
  output logic o_resp_valid,                    // Response pulse
  output logic [31:0] o_resp_data,              // Response data
  output bdcu_pkg::bdcu_reg_req_t o_reg_req,    // Core register request
  input wire logic i_reg_ack,                   // Register access done
  input wire logic [31:0] i_reg_rdata,          // Register read data
  input wire logic [2:0] i_source_space_select, // Current source function code
  input wire logic [2:0] i_dest_space_select,   // Current destination function code
  output bdcu_pkg::bdcu_mem_req_t o_mem_req,    // Memory request
  input wire logic i_mem_ack,                   // Memory access done
  input wire logic [31:0] i_mem_rdata,          // Memory read data
  input wire logic [31:0] i_pc,                 // Current program counter
  output logic o_resume,                        // Pulse: flush pipe, resume at PC
  output logic o_call,                          // Pulse: begin patch code
  output logic o_periph_rst_b                   // Peripheral reset, active low
);

  // Whole controller state
  typedef struct packed {
    bdcu_pkg::bdcu_state_t fsm;   // Sequencer state
    logic [3:0] op;               // Command in progress
    logic [1:0] size;             // Operand size of block transfers
    logic [31:0] blk_addr;        // Next block address
    logic [31:0] stk;             // Stack pointer for patch call
    logic ready;                  // Registered ready
    logic resp_valid;             // Registered response strobe
    logic [31:0] resp_data;       // Registered response data
    bdcu_pkg::bdcu_reg_req_t reg_req;  // Registered register request
    bdcu_pkg::bdcu_mem_req_t mem_req;  // Registered memory request
    logic resume;                 // Registered resume pulse
    logic call;                   // Registered call pulse
    logic rst_go;                 // Start peripheral reset
  } bdcu_core_t;

  bdcu_core_t st;       // Current state
  bdcu_core_t next_st;  // Next state

  logic rst_busy;  // Peripheral reset in progress

  // Size in bytes for block address stepping
  function automatic logic [31:0] size_step(input logic [1:0] sz);
    logic [31:0] step;
    step = 32'h00000004;
    if (sz == `BDCU_SZ_BYTE) begin
      step = 32'h00000001;
    end else if (sz == `BDCU_SZ_WORD) begin
      step = 32'h00000002;
    end
    return step;
  endfunction

  logic take;  // Command accepted this cycle
  assign take = i_cmd_valid && st.ready && i_halted;

  // Sequencer
  always_comb begin
    next_st = st;
    next_st.resp_valid = 1'b0;
    next_st.resume = 1'b0;
    next_st.call = 1'b0;
    next_st.rst_go = 1'b0;
    next_st.reg_req.rd = 1'b0;
    next_st.reg_req.wr = 1'b0;
    next_st.mem_req.rd = 1'b0;
    next_st.mem_req.wr = 1'b0;
    unique case (st.fsm)
      // Idle: take one command
      bdcu_pkg::BDCU_IDLE: begin
        if (take) begin
          next_st.ready = 1'b0;  // One command at a time
          next_st.op = i_cmd.op;
          next_st.fsm = bdcu_pkg::BDCU_RESP;
          case (i_cmd.op)
            // Data or address register read
            `BDCU_OP_RDDAT, `BDCU_OP_RDADR: begin
              next_st.reg_req.rd = 1'b1;
              next_st.reg_req.sys = 1'b0;
              next_st.reg_req.sel = {i_cmd.op == `BDCU_OP_RDADR, i_cmd.sel};
              next_st.fsm = bdcu_pkg::BDCU_REG_WAIT;
            end
            // Data or address register write
            `BDCU_OP_WRDAT, `BDCU_OP_WRADR: begin
              next_st.reg_req.wr = 1'b1;
              next_st.reg_req.sys = 1'b0;
              next_st.reg_req.sel = {i_cmd.op == `BDCU_OP_WRADR, i_cmd.sel};
              next_st.reg_req.data = i_cmd.data;
              next_st.fsm = bdcu_pkg::BDCU_REG_WAIT;
            end
            // System register read
            `BDCU_OP_RDSYS: begin
              next_st.reg_req.rd = 1'b1;  // Any supervisor register
              next_st.reg_req.sys = 1'b1;
              next_st.reg_req.sel = {1'b0, i_cmd.sel};
              next_st.fsm = bdcu_pkg::BDCU_REG_WAIT;
            end
            // System register write
            `BDCU_OP_WRSYS: begin
              next_st.reg_req.wr = 1'b1;
              next_st.reg_req.sys = 1'b1;
              next_st.reg_req.sel = {1'b0, i_cmd.sel};
              next_st.reg_req.data = i_cmd.data;
              next_st.fsm = bdcu_pkg::BDCU_REG_WAIT;
            end
            // Memory read or next block read
            `BDCU_OP_READ, `BDCU_OP_DUMP: begin
              next_st.mem_req.rd = 1'b1;
              next_st.mem_req.space = i_source_space_select;
              // Dump continues from the address the last read, write, dump or fill left
              next_st.mem_req.addr = (i_cmd.op == `BDCU_OP_READ) ? i_cmd.addr : st.blk_addr;
              next_st.mem_req.size = (i_cmd.op == `BDCU_OP_READ) ? i_cmd.size : st.size;
              next_st.size = next_st.mem_req.size;
              next_st.fsm = bdcu_pkg::BDCU_MEM_WAIT;
            end
            // Memory write or next block write
            `BDCU_OP_WRITE, `BDCU_OP_FILL: begin
              next_st.mem_req.wr = 1'b1;
              next_st.mem_req.space = i_dest_space_select;
              // Fill continues from the address the last read, write, dump or fill left
              next_st.mem_req.addr = (i_cmd.op == `BDCU_OP_WRITE) ? i_cmd.addr : st.blk_addr;
              next_st.mem_req.size = (i_cmd.op == `BDCU_OP_WRITE) ? i_cmd.size : st.size;
              next_st.mem_req.data = i_cmd.data;
              next_st.size = next_st.mem_req.size;
              next_st.fsm = bdcu_pkg::BDCU_MEM_WAIT;
            end
            // Resume execution
            `BDCU_OP_GO: begin
              next_st.resume = 1'b1;  // Flush and refill, run from PC
            end
            // Patch call: stack pointer first
            `BDCU_OP_CALL: begin
              next_st.reg_req.rd = 1'b1;  // Fetch active stack pointer
              next_st.reg_req.sys = 1'b0;
              next_st.reg_req.sel = 5'h17;
              next_st.fsm = bdcu_pkg::BDCU_CALL_SP;
            end
            // Peripheral reset
            `BDCU_OP_RST: begin
              // Only the peripheral line pulses; core state untouched
              next_st.rst_go = !rst_busy;
            end
            default: begin
              // Null and unknown commands change nothing
            end
          endcase
        end
      end
      // Wait for the register file
      bdcu_pkg::BDCU_REG_WAIT: begin
        if (i_reg_ack) begin
          next_st.resp_data = i_reg_rdata;
          next_st.fsm = bdcu_pkg::BDCU_RESP;
        end
      end
      // Wait for memory, step block address
      bdcu_pkg::BDCU_MEM_WAIT: begin
        if (i_mem_ack) begin
          next_st.resp_data = i_mem_rdata;
          next_st.blk_addr = st.mem_req.addr + size_step(st.size);
          next_st.fsm = bdcu_pkg::BDCU_RESP;
        end
      end
      // Stack pointer in: push the PC
      bdcu_pkg::BDCU_CALL_SP: begin
        if (i_reg_ack) begin
          // Push PC below the current stack pointer
          next_st.stk = i_reg_rdata - `BDCU_PC_BYTES;
          next_st.mem_req.wr = 1'b1;
          next_st.mem_req.space = i_dest_space_select;
          next_st.mem_req.size = `BDCU_SZ_LONG;
          next_st.mem_req.addr = i_reg_rdata - `BDCU_PC_BYTES;
          next_st.mem_req.data = i_pc;
          next_st.fsm = bdcu_pkg::BDCU_CALL_PUSH;
        end
      end
      // Push done: start patch code
      bdcu_pkg::BDCU_CALL_PUSH: begin
        if (i_mem_ack) begin
          next_st.call = 1'b1;  // Begin patch code after stacking
          next_st.fsm = bdcu_pkg::BDCU_RESP;
        end
      end
      // Answer and become ready
      bdcu_pkg::BDCU_RESP: begin
        next_st.resp_valid = 1'b1;
        next_st.ready = 1'b1;
        next_st.fsm = bdcu_pkg::BDCU_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      st <= '0;
      st.fsm <= bdcu_pkg::BDCU_IDLE;
      st.ready <= 1'b1;
      st.size <= `BDCU_SZ_LONG;
    end else begin
      st <= next_st;
    end
  end

  // Peripheral reset pulse generator
  bdcu_rst_pulse #(
    .CYCLES(RST_CYCLES)
  ) u_rst_pulse (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_start(st.rst_go),
    .o_periph_rst_b(o_periph_rst_b),
    .o_busy(rst_busy)
  );

  assign o_cmd_ready = st.ready;
  assign o_resp_valid = st.resp_valid;
  assign o_resp_data = st.resp_data;
  assign o_reg_req = st.reg_req;
  assign o_mem_req = st.mem_req;
  assign o_resume = st.resume;
  assign o_call = st.call;

  // Sequences for the patch call
  sequence s_call_fetch;
    o_reg_req.rd && !o_reg_req.sys && o_reg_req.sel == 5'h17;
  endsequence

  sequence s_call_push;
    o_mem_req.wr && o_mem_req.data == $past(i_pc);
  endsequence

  // Command acceptance, request and response checks

  a_halt_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_cmd_valid && !i_halted && st.fsm == bdcu_pkg::BDCU_IDLE)
      |=> st.fsm == bdcu_pkg::BDCU_IDLE)
    else $error("command taken while not halted");

  a_one_at_time: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    take |=> !o_cmd_ready)
    else $error("ready stayed high after accept");

  a_read_space: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_READ)
      |=> o_mem_req.rd && o_mem_req.space == $past(i_source_space_select))
    else $error("read used wrong address space");

  a_write_space: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_WRITE)
      |=> o_mem_req.wr && o_mem_req.space == $past(i_dest_space_select))
    else $error("write used wrong address space");

  a_write_data: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_WRITE)
      |=> o_mem_req.data == $past(i_cmd.data) && o_mem_req.addr == $past(i_cmd.addr))
    else $error("write operand or address wrong");

  a_reg_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_WRDAT)
      |=> o_reg_req.wr && !o_reg_req.sys && o_reg_req.data == $past(i_cmd.data))
    else $error("register write not issued");

  a_sys_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_WRSYS) |=> o_reg_req.wr && o_reg_req.sys)
    else $error("system register write not issued");

  a_sys_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_RDSYS)
      |=> o_reg_req.rd && o_reg_req.sys && o_reg_req.sel[3:0] == $past(i_cmd.sel))
    else $error("system register read not issued");

  a_reg_read_resp: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (st.fsm == bdcu_pkg::BDCU_REG_WAIT && i_reg_ack && st.op == `BDCU_OP_RDDAT)
      |=> ##1 o_resp_valid && o_resp_data == $past(i_reg_rdata, 2))
    else $error("register read data not returned");

  a_dump_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_DUMP)
      |=> o_mem_req.rd && o_mem_req.addr == $past(st.blk_addr))
    else $error("dump address not advanced");

  a_fill_addr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_FILL)
      |=> o_mem_req.wr && o_mem_req.addr == $past(st.blk_addr))
    else $error("fill address not advanced");

  a_resume_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_GO) |=> o_resume ##1 !o_resume)
    else $error("resume pulse wrong");

  a_call_order: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_call)
      |-> $past(st.fsm) == bdcu_pkg::BDCU_CALL_PUSH && $past(i_mem_ack))
    else $error("patch code started before stacking");

  a_call_push: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (st.fsm == bdcu_pkg::BDCU_CALL_SP && i_reg_ack) |=> s_call_push)
    else $error("pc not pushed");

  a_call_fetch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_CALL) |=> s_call_fetch)
    else $error("stack pointer not fetched");

  a_null_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_NOP)
      |=> !o_reg_req.rd && !o_reg_req.wr && !o_mem_req.rd && !o_mem_req.wr ##1 o_resp_valid)
    else $error("null command had an effect");

  a_rst_core_ok: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (take && i_cmd.op == `BDCU_OP_RST) |=> ##1 o_resp_valid && o_cmd_ready)
    else $error("core disturbed by peripheral reset");

endmodule
`default_nettype wire

// [sim/bdcu_far_model.sv]
// Far-side model: core register file and memory that answer the command unit
// Assumes one system clock and the one-cycle request strobes of bdcu_pkg
`timescale 1ns/1ps
`default_nettype none
module bdcu_far_model (
  input wire logic i_sys_clk,                    // System clock
  input wire logic i_rst_b,                      // Sync reset, active low
  input wire logic i_slow,                       // Answer after three cycles
  input wire bdcu_pkg::bdcu_reg_req_t i_reg_req, // Register request
  output logic o_reg_ack,                        // Register access done
  output logic [31:0] o_reg_rdata,               // Register read data
  input wire bdcu_pkg::bdcu_mem_req_t i_mem_req, // Memory request
  output logic o_mem_ack,                        // Memory access done
  output logic [31:0] o_mem_rdata                // Memory read data
);
  logic [31:0] regs [64]; // Indexed by {sys, addr_not_data, index}
  logic [31:0] mem [256]; // Word store keyed by the low address byte
  logic [1:0] rcnt;       // Register answer delay
  logic [1:0] mcnt;       // Memory answer delay
  logic rwr;              // Pending register access is a write
  logic mwr;              // Pending memory access is a write
  logic [5:0] ridx;       // Register index of the held request

  // System registers ignore the top select bit
  assign ridx = {i_reg_req.sys, i_reg_req.sys ? 1'b0 : i_reg_req.sel[4], i_reg_req.sel[3:0]};

  // Both sides: data valid only with the ack, a changing pattern otherwise
  always @(posedge i_sys_clk) begin
    o_reg_ack <= 1'b0;
    o_mem_ack <= 1'b0;
    o_reg_rdata <= ~o_reg_rdata;
    o_mem_rdata <= ~o_mem_rdata;
    if (!i_rst_b) begin
      rcnt <= 2'h0;
      mcnt <= 2'h0;
      for (int i = 0; i < 64; i++)
        regs[i] <= 32'h40000000 | i;
      for (int i = 0; i < 256; i++)
        mem[i] <= 32'h5a000000 | i;
    end else begin
      // Register access
      if (i_reg_req.rd || i_reg_req.wr) begin
        rcnt <= i_slow ? 2'h3 : 2'h1;
        rwr <= i_reg_req.wr;
      end else if (rcnt != 2'h0) begin
        rcnt <= rcnt - 2'h1;
        if (rcnt == 2'h1) begin
          o_reg_ack <= 1'b1;
          o_reg_rdata <= regs[ridx];
          if (rwr)
            regs[ridx] <= i_reg_req.data;
        end
      end
      // Memory access
      if (i_mem_req.rd || i_mem_req.wr) begin
        mcnt <= i_slow ? 2'h3 : 2'h1;
        mwr <= i_mem_req.wr;
      end else if (mcnt != 2'h0) begin
        mcnt <= mcnt - 2'h1;
        if (mcnt == 2'h1) begin
          o_mem_ack <= 1'b1;
          o_mem_rdata <= mem[i_mem_req.addr[7:0]];
          if (mwr)
            mem[i_mem_req.addr[7:0]] <= i_mem_req.data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [sim/test_background_debug_command_unit.sv]
// Self-checking bench for the debug command unit with a far-side model
// Assumes bdcu_params.svh on the include path and a short reset pulse length
`timescale 1ns/1ps
`default_nettype none
`include "bdcu_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_background_debug_command_unit;
  localparam int RCYC = 16; // Shortened peripheral reset length
  logic clk, rst_b, halted, cmd_valid, slow, reg_ack, mem_ack, resume, call, prst_b, ready, resp;
  logic [2:0] ssel, dsel;
  logic [31:0] pc, reg_rd, mem_rd, resp_data, keep;
  bdcu_pkg::bdcu_cmd_t cmd;
  bdcu_pkg::bdcu_reg_req_t reg_req;
  bdcu_pkg::bdcu_mem_req_t mem_req;
  int num_errors = 0, check_count = 0, n_resp = 0, n_resume = 0, n_call = 0, n_reg = 0, n_mem = 0, n_low = 0;
  int c0, c1, c2;

  bdcu_core #(.RST_CYCLES(10'h010)) u_dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_halted(halted),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(ready), .o_resp_valid(resp),
    .o_resp_data(resp_data), .o_reg_req(reg_req), .i_reg_ack(reg_ack), .i_reg_rdata(reg_rd),
    .i_source_space_select(ssel), .i_dest_space_select(dsel), .o_mem_req(mem_req), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rd), .i_pc(pc), .o_resume(resume), .o_call(call), .o_periph_rst_b(prst_b));
  bdcu_far_model u_far (.i_sys_clk(clk), .i_rst_b(rst_b), .i_slow(slow), .i_reg_req(reg_req),
    .o_reg_ack(reg_ack), .o_reg_rdata(reg_rd), .i_mem_req(mem_req), .o_mem_ack(mem_ack), .o_mem_rdata(mem_rd));

  // Clock at 10 MHz
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Count pulses and reset-low cycles where outputs are settled
  always @(negedge clk) begin
    n_resp += int'(resp === 1'b1);
    n_resume += int'(resume === 1'b1);
    n_call += int'(call === 1'b1);
    n_reg += int'((reg_req.rd | reg_req.wr) === 1'b1);
    n_mem += int'((mem_req.rd | mem_req.wr) === 1'b1);
    n_low += int'(prst_b === 1'b0);
  end

  // Print the counts and the verdict, then stop
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Offer one command at a falling edge and wait for its response pulse
  task automatic do_cmd(input logic [3:0] op, input logic [1:0] sz, input logic [3:0] sel,
                        input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    cmd = '{op: op, size: sz, sel: sel, addr: a, data: d};
    cmd_valid = 1'b1;
    @(negedge clk);
    cmd_valid = 1'b0;
    n = (n >= 200) ? 50 : 0;  // A ready timeout fails at once
    while (resp !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask

  // Data and address registers, quick and slow answers
  task automatic t_regs();
    slow = 1'b0;
    do_cmd(`BDCU_OP_WRDAT, 2'h0, 4'h3, 32'h0, 32'h12345678);
    do_cmd(`BDCU_OP_RDDAT, 2'h0, 4'h3, 32'h0, 32'h0);
    `CHK(resp_data, 32'h12345678)
    slow = 1'b1;
    do_cmd(`BDCU_OP_WRADR, 2'h0, 4'h2, 32'h0, 32'hcafe0002);
    do_cmd(`BDCU_OP_RDADR, 2'h0, 4'h2, 32'h0, 32'h0);
    `CHK(resp_data, 32'hcafe0002)
    `CHK(reg_req.sel, 5'h12)
    do_cmd(`BDCU_OP_RDADR, 2'h0, 4'h4, 32'h0, 32'h0);
    `CHK(resp_data, 32'h40000014)
    slow = 1'b0;
  endtask

  // System registers
  task automatic t_sys();
    do_cmd(`BDCU_OP_WRSYS, 2'h0, 4'h5, 32'h0, 32'h0000beef);
    `CHK(reg_req.sys, 1'b1)
    do_cmd(`BDCU_OP_RDSYS, 2'h0, 4'h5, 32'h0, 32'h0);
    `CHK(resp_data, 32'h0000beef)
    do_cmd(`BDCU_OP_RDSYS, 2'h0, 4'h6, 32'h0, 32'h0);
    `CHK(resp_data, 32'h40000026)
  endtask

  // Memory write then read, spaces from the two function codes
  task automatic t_mem();
    dsel = 3'h5;
    ssel = 3'h3;
    do_cmd(`BDCU_OP_WRITE, `BDCU_SZ_LONG, 4'h0, 32'h20, 32'h89abcdef);
    `CHK(mem_req.space, 3'h5)
    `CHK({mem_req.size, mem_req.addr}, {`BDCU_SZ_LONG, 32'h20})
    do_cmd(`BDCU_OP_READ, `BDCU_SZ_LONG, 4'h0, 32'h20, 32'h0);
    `CHK(resp_data, 32'h89abcdef)
    `CHK(mem_req.space, 3'h3)
  endtask

  // Fill then dump a block; address steps for byte and word sizes
  task automatic t_block();
    do_cmd(`BDCU_OP_WRITE, `BDCU_SZ_LONG, 4'h0, 32'h40, 32'h11111111);
    do_cmd(`BDCU_OP_FILL, `BDCU_SZ_LONG, 4'h0, 32'h0, 32'h22222222);
    `CHK(mem_req.addr, 32'h44)
    do_cmd(`BDCU_OP_FILL, `BDCU_SZ_LONG, 4'h0, 32'h0, 32'h33333333);
    do_cmd(`BDCU_OP_READ, `BDCU_SZ_LONG, 4'h0, 32'h40, 32'h0);
    `CHK(resp_data, 32'h11111111)
    do_cmd(`BDCU_OP_DUMP, `BDCU_SZ_LONG, 4'h0, 32'h0, 32'h0);
    `CHK(resp_data, 32'h22222222)
    do_cmd(`BDCU_OP_DUMP, `BDCU_SZ_LONG, 4'h0, 32'h0, 32'h0);
    `CHK(resp_data, 32'h33333333)
    for (int s = 0; s < 2; s++) begin
      do_cmd(`BDCU_OP_READ, 2'(s), 4'h0, 32'h80, 32'h0);
      do_cmd(`BDCU_OP_DUMP, 2'h3, 4'h0, 32'h0, 32'h0);
      `CHK({mem_req.size, mem_req.addr}, {2'(s), 32'h80 + (32'h1 << s)})
    end
  endtask

  // Resume, patch call and null command
  task automatic t_flow();
    c0 = n_resume;
    c1 = n_reg + n_mem;
    do_cmd(`BDCU_OP_GO, 2'h0, 4'h0, 32'h0, 32'h0);
    `CHK(n_resume - c0, 1)
    `CHK(n_reg + n_mem - c1, 0)
    pc = 32'h00001234;
    dsel = 3'h6;
    c0 = n_call;
    do_cmd(`BDCU_OP_CALL, 2'h0, 4'h0, 32'h0, 32'h0);
    `CHK({mem_req.addr, mem_req.data}, {32'h40000013, 32'h00001234})
    `CHK({mem_req.space, mem_req.size}, {3'h6, `BDCU_SZ_LONG})
    `CHK(n_call - c0, 1)
    keep = resp_data;
    c0 = n_reg + n_mem;
    c1 = n_resume + n_call;
    do_cmd(`BDCU_OP_NOP, 2'h0, 4'h0, 32'h0, 32'h0);
    `CHK(resp_data, keep)
    `CHK(n_reg + n_mem + n_resume + n_call - c0 - c1, 0)
  endtask

  // Peripheral reset: exact length, core still answers, a second one ignored
  task automatic t_rst();
    int n;
    c0 = n_low;
    do_cmd(`BDCU_OP_RST, 2'h0, 4'h0, 32'h0, 32'h0);
    do_cmd(`BDCU_OP_RDDAT, 2'h0, 4'h3, 32'h0, 32'h0);
    `CHK(resp_data, 32'h12345678)
    do_cmd(`BDCU_OP_RST, 2'h0, 4'h0, 32'h0, 32'h0);
    n = 0;
    while (prst_b !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      final_report();
    end
    repeat (4) @(negedge clk);
    `CHK(n_low - c0, RCYC)
  endtask

  // Commands offered while running are ignored
  task automatic t_halt();
    halted = 1'b0;
    c0 = n_resp;
    c2 = n_reg;
    cmd = '{op: `BDCU_OP_WRDAT, size: 2'h0, sel: 4'h3, addr: 32'h0, data: 32'h0};
    cmd_valid = 1'b1;
    repeat (3) @(negedge clk);
    cmd_valid = 1'b0;
    repeat (10) @(negedge clk);
    `CHK(n_resp - c0 + n_reg - c2, 0)
    halted = 1'b1;
    do_cmd(`BDCU_OP_RDDAT, 2'h0, 4'h3, 32'h0, 32'h0);
    `CHK(resp_data, 32'h12345678)
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    halted = 1'b1;
    cmd_valid = 1'b0;
    cmd = '0;
    slow = 1'b0;
    ssel = 3'h1;
    dsel = 3'h1;
    pc = 32'h0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    `CHK({ready, prst_b, resp_data}, {2'b11, 32'h0})
    t_regs();
    t_sys();
    t_mem();
    t_block();
    t_flow();
    t_rst();
    t_halt();
    final_report();
  end
endmodule
`default_nettype wire
